// ==== sup_wdog_regs.vh ====
// Constants for the supervisor reset and watchdog block.
// Assumes a 200 MHz system clock; included by sup_wdog.v only.
`ifndef SUP_WDOG_REGS_VH
`define SUP_WDOG_REGS_VH
// Nominal reset pulse time in ms and watchdog period in ms.
`define SW_PULSE_MS 200
`define SW_WDOG_MS 1600
// Clock rate in kHz (cycles per ms).
`define SW_CLK_KHZ 200000
// Shortest service pulse in ns, and the clock period in ns.
`define SW_SVC_NS 50
`define SW_CLK_NS 5
// Trip levels in millivolts for the two threshold variants.
`define SW_TRIP_HI_MV 4650
`define SW_TRIP_LO_MV 4400
// Counter width, enough for the longest interval in cycles.
`define SW_CNT_W 32
`define SW_CNT_ZERO 32'h0000_0000
`define SW_CNT_ONE 32'h0000_0001
`endif

// ==== sup_wdog.v ====
// Supervisor logic: timed reset pulse, watchdog and supply switchover.
// Assumes comparator flags arrive already synchronised to sys_clk and that
// rstn is released only once the supply-good condition holds.
`timescale 1ns/10ps
`include "sup_wdog_regs.vh"
module sup_wdog #(
   parameter INVERT_RESET = 0,
   parameter TRIP_MV = `SW_TRIP_HI_MV,
   parameter [`SW_CNT_W-1:0] PULSE_CYC = `SW_PULSE_MS * `SW_CLK_KHZ,
   parameter [`SW_CNT_W-1:0] WDOG_CYC = `SW_WDOG_MS * `SW_CLK_KHZ
) (
   sys_clk,
   rstn,
   supplyAboveTrip,
   supplyAboveBackup,
   supplyCollapsed,
   backupPresent,
   watchdogServiceIn,
   watchdogFloating,
   earlyFailSenseIn,
   resetOut,
   earlyFailFlagN,
   useBackup,
   comparatorsOn,
   tripLevelMv
);
   input wire sys_clk;
   input wire rstn;
   input wire supplyAboveTrip;
   input wire supplyAboveBackup;
   input wire supplyCollapsed;
   input wire backupPresent;
   input wire watchdogServiceIn;
   input wire watchdogFloating;
   input wire earlyFailSenseIn;
   output reg resetOut;
   output reg earlyFailFlagN;
   output reg useBackup;
   output reg comparatorsOn;
   output reg [15:0] tripLevelMv;

   // ************************************************************
   // Local states and derived counts.
   // ************************************************************
   localparam [2:0] ST_LOW = 3'b001;
   localparam [2:0] ST_PULSE = 3'b010;
   localparam [2:0] ST_RUN = 3'b100;
   // A 50 ns service pulse spans ten clocks, so one sample is enough.

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [`SW_CNT_W-1:0] cnt_reg;
   reg [`SW_CNT_W-1:0] cnt_next;
   reg wdiLast_reg;
   reg asserted;
   wire serviced;

   // Terminal-count test shared by the pulse and watchdog timers.
   function done;
      input [`SW_CNT_W-1:0] c;
      input [`SW_CNT_W-1:0] lim;
      begin
         done = (c >= lim - `SW_CNT_ONE);
      end
   endfunction

   // ************************************************************
   // Watchdog service detection.
   // ************************************************************
   // Any level change sampled at the clock is a service; a pulse of one
   // clock or more is always seen, so the 50 ns minimum is met.
   assign serviced = (watchdogServiceIn != wdiLast_reg) |
                     watchdogFloating;

   // Edge history register; it samples the line every clock, backup mode included.
   // It resets low, so a line idling high reads as one service after
   // reset; that only restarts the count and so is harmless.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wdiLast_reg <= 1'b0;
      end else begin
         wdiLast_reg <= watchdogServiceIn;
      end
   end

   // ************************************************************
   // Reset and watchdog sequencer.
   // ************************************************************
   // Low supply holds reset; a pulse follows recovery or a timeout, then
   // the watchdog counts until serviced or expired.
   always @* begin
      state_next = state_reg;
      cnt_next = cnt_reg + `SW_CNT_ONE;
      case (state_reg)
         ST_LOW: begin
            cnt_next = `SW_CNT_ZERO;
            if (supplyAboveTrip) begin
               state_next = ST_PULSE;
            end
         end
         ST_PULSE: begin
            if (!supplyAboveTrip) begin
               state_next = ST_LOW;
               cnt_next = `SW_CNT_ZERO;
            end else if (done(cnt_reg, PULSE_CYC)) begin
               state_next = ST_RUN;
               cnt_next = `SW_CNT_ZERO;
            end
         end
         ST_RUN: begin
            if (!supplyAboveTrip) begin
               state_next = ST_LOW;
               cnt_next = `SW_CNT_ZERO;
            end else if (serviced) begin
               cnt_next = `SW_CNT_ZERO;
            end else if (done(cnt_reg, WDOG_CYC)) begin
               state_next = ST_PULSE;
               cnt_next = `SW_CNT_ZERO;
            end
         end
         default: begin
            state_next = ST_LOW;
            cnt_next = `SW_CNT_ZERO;
         end
      endcase
   end

   // Sequencer state; all timing counts clocks of sys_clk.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_LOW;
         cnt_reg <= `SW_CNT_ZERO;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // ************************************************************
   // Outputs and supply switchover.
   // ************************************************************
   // The reset output is registered from next state so it tracks the state exactly.
   // Using state_next rather than state_reg saves a cycle of lag, so
   // reset drops on the very edge at which the supply loss is seen.
   always @* begin
      asserted = (state_next != ST_RUN);
   end

   // Reset output; asserted means the processor is held.
   // The polarity is fixed per variant at build time, never at run time.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resetOut <= (INVERT_RESET != 0) ? 1'b1 : 1'b0;
      end else begin
         resetOut <= (INVERT_RESET != 0) ? asserted : ~asserted;
      end
   end

   // Trip level report, a constant of the variant once out of reset.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tripLevelMv <= 16'h0000;
      end else begin
         tripLevelMv <= TRIP_MV[15:0];
      end
   end

   // Supply switchover. Leaving backup takes priority over entering it,
   // so a supply above the trip level always returns to main at once.
   // A floating backup pin never qualifies, which keeps battery swaps safe.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         useBackup <= 1'b0;
      end else if (supplyAboveTrip) begin
         useBackup <= 1'b0;
      end else if (!supplyAboveBackup && backupPresent) begin
         useBackup <= 1'b1;
      end
   end

   // Fail flag forced low in backup; the sense input is ignored there.
   // In normal running the flag follows the sense input one clock late.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         earlyFailFlagN <= 1'b0;
      end else if (useBackup) begin
         earlyFailFlagN <= 1'b0;
      end else begin
         earlyFailFlagN <= earlyFailSenseIn;
      end
   end

   // Comparators go dark once the supply has collapsed in backup. They
   // come back as soon as either condition clears, one clock later.
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         comparatorsOn <= 1'b1;
      end else begin
         comparatorsOn <= ~(useBackup & supplyCollapsed);
      end
   end
   // Backup mode implies supply below trip, so the sequencer sits in its
   // low state: reset held and the watchdog counter cleared.
endmodule

// ==== sup_wdog_assertions.sv ====
// Checker of the supervisor ports, active-low reset output variant.
// Assumes it is bound into the block with both count parameters.
`timescale 1ns/10ps
module sup_wdog_assertions #(parameter PULSE_CYC = 20, WDOG_CYC = 50) (
   input wire sys_clk, rstn, supplyAboveTrip, supplyAboveBackup,
   input wire supplyCollapsed, backupPresent, watchdogServiceIn,
   input wire earlyFailSenseIn, resetOut, earlyFailFlagN, useBackup,
   input wire comparatorsOn
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // Low supply and backup mode must both force the reset output.
   a_low_supply_reset: assert property (
      !supplyAboveTrip |=> !resetOut) else $error("reset not held");
   a_backup_holds: assert property (
      useBackup && $past(useBackup) |-> !resetOut && !earlyFailFlagN)
      else $error("backup outputs wrong");
   a_backup_entry: assert property (
      $rose(useBackup) |-> !$past(supplyAboveTrip) &&
      !$past(supplyAboveBackup) && $past(backupPresent))
      else $error("bad switch to backup");
   a_main_return: assert property (
      supplyAboveTrip |=> !useBackup) else $error("backup kept");
   a_comp_shutoff: assert property (
      useBackup && supplyCollapsed && !supplyAboveTrip |=> !comparatorsOn)
      else $error("comparators left on");
   // The flag is checked only once backup has been left for a cycle.
   a_flag_follows: assert property (
      $past(rstn) && !useBackup && !$past(useBackup) |->
      earlyFailFlagN == $past(earlyFailSenseIn)) else $error("flag lag");
   a_pulse_width: assert property (
      $rose(resetOut) |-> !$past(resetOut, PULSE_CYC) &&
      $past(supplyAboveTrip, PULSE_CYC)) else $error("short pulse");
   a_wdog_cause: assert property (
      $fell(resetOut) && $past(supplyAboveTrip) |->
      $past(watchdogServiceIn) == $past(watchdogServiceIn, WDOG_CYC - 1))
      else $error("reset without timeout");
endmodule

// ==== sup_cpu_model.sv ====
// Processor model that services the watchdog line while out of reset.
// Assumes the active-low reset output variant.
`timescale 1ns/10ps
module sup_cpu_model #(parameter HALF = 10) (
   input wire sys_clk,
   input wire resetOut,
   input wire serviceOn,
   output logic watchdogServiceIn
);
   int cnt = 0;
   initial watchdogServiceIn = 1'b0;
   // Each level is held ten cycles, the shortest valid service pulse.
   always @(negedge sys_clk) begin
      if (serviceOn && resetOut) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) watchdogServiceIn <= ~watchdogServiceIn;
      end
   end
endmodule

// ==== sup_wdog_tb.sv ====
// Self-checking bench for the supervisor block and its processor model.
// Assumes the block, checker and model files are compiled first.
`timescale 1ns/10ps
module tb;
   localparam P = 20;
   localparam W = 50;
   logic sys_clk = 0, rstn = 0, supplyAboveTrip = 0, supplyAboveBackup = 1;
   logic supplyCollapsed = 0, backupPresent = 1, watchdogFloating = 0;
   logic earlyFailSenseIn = 1, serviceOn = 1;
   wire watchdogServiceIn, resetOut, earlyFailFlagN, useBackup, comparatorsOn;
   wire [15:0] tripLevelMv;
   wire [3:0] outs = {useBackup, comparatorsOn, earlyFailFlagN, resetOut};
   int errors = 0, compares = 0, cyc = 0, n, n1;
   // Rows: trip, above backup, collapsed, present, sense; then outputs.
   logic [8:0] rows [5] = '{9'h03c, 9'h078, 9'h1b6, 9'h016, 9'h0a4};
   sup_wdog #(.PULSE_CYC(P), .WDOG_CYC(W)) sup_wdog_i (.sys_clk(sys_clk),
      .rstn(rstn), .supplyAboveTrip(supplyAboveTrip),
      .supplyAboveBackup(supplyAboveBackup),
      .supplyCollapsed(supplyCollapsed), .backupPresent(backupPresent),
      .watchdogServiceIn(watchdogServiceIn),
      .watchdogFloating(watchdogFloating),
      .earlyFailSenseIn(earlyFailSenseIn), .resetOut(resetOut),
      .earlyFailFlagN(earlyFailFlagN), .useBackup(useBackup),
      .comparatorsOn(comparatorsOn), .tripLevelMv(tripLevelMv));
   sup_cpu_model sup_cpu_model_i (.sys_clk(sys_clk), .resetOut(resetOut),
      .serviceOn(serviceOn), .watchdogServiceIn(watchdogServiceIn));
   initial forever #2.5 sys_clk = ~sys_clk;
   // A hung wait is cut short well beyond the expected run length.
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         errors++;
         stop_test;
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Counts cycles until the reset output reaches a level, bounded.
   task meas(input logic lvl, input int lim);
      n = 0;
      while (resetOut !== lvl && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task stop_test;
      if (errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge sys_clk);
      rstn = 1;
      foreach (rows[i]) begin
         {supplyAboveTrip, supplyAboveBackup, supplyCollapsed, backupPresent,
            earlyFailSenseIn} = rows[i][8:4];
         repeat (3) @(negedge sys_clk);
         chk(outs, rows[i][3:0]);
      end
      supplyAboveTrip = 1;
      meas(1, 500);
      chk(n >= P && n <= P + 3, 1);
      chk(tripLevelMv, 16'h122a);
      meas(0, 3 * W);
      chk(n, 3 * W);
      // A stuck service line must give repeated pulses.
      serviceOn = 0;
      meas(0, 500);
      chk(n >= W - 10 && n <= W + 3, 1);
      meas(1, 500);
      n1 = n;
      meas(0, 500);
      chk(n1 + n >= P + W && n1 + n <= P + W + 5, 1);
      watchdogFloating = 1;
      meas(1, 500);
      meas(0, 3 * W);
      chk(n, 3 * W);
      supplyAboveTrip = 0;
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk(resetOut, 0);
      supplyAboveTrip = 1;
      meas(1, 500);
      chk(n >= P && n <= P + 3, 1);
      // Battery pulled while the supply is good: no switchover, no reset.
      backupPresent = 0;
      supplyAboveBackup = 0;
      repeat (2) @(negedge sys_clk);
      chk({useBackup, resetOut}, 2'b01);
      // Mid-run reset, then a fresh power-up pulse after release.
      rstn = 0;
      @(negedge sys_clk);
      chk(outs, 4'h4);
      chk(tripLevelMv, 16'h0000);
      repeat (2) @(negedge sys_clk);
      rstn = 1;
      meas(1, 500);
      chk(n >= P && n <= P + 3, 1);
      chk(tripLevelMv, 16'h122a);
      stop_test;
   end
endmodule
bind sup_wdog sup_wdog_assertions #(.PULSE_CYC(PULSE_CYC),
   .WDOG_CYC(WDOG_CYC)) sup_wdog_assertions_i (.sys_clk(sys_clk),
   .rstn(rstn), .supplyAboveTrip(supplyAboveTrip),
   .supplyAboveBackup(supplyAboveBackup), .supplyCollapsed(supplyCollapsed),
   .backupPresent(backupPresent), .watchdogServiceIn(watchdogServiceIn),
   .earlyFailSenseIn(earlyFailSenseIn), .resetOut(resetOut),
   .earlyFailFlagN(earlyFailFlagN), .useBackup(useBackup),
   .comparatorsOn(comparatorsOn));
